// ---- rmcr_defs.svh ----
// Constants for the radio modem configuration register bank
`ifndef RMCR_DEFS_SVH
`define RMCR_DEFS_SVH
// ----------------------------------------
// Register numbers
// ----------------------------------------
`define RMCR_REG_RF_LEVEL 9'h0E7
`define RMCR_REG_RATE 9'h0D2
`define RMCR_REG_DATA_LEN 9'h0D3
`define RMCR_REG_PARITY 9'h0D4
`define RMCR_REG_STOP 9'h0D5
`define RMCR_REG_ESC_TMO 9'h0D6
`define RMCR_REG_IF_TYPE 9'h0D7
`define RMCR_REG_FLOW 9'h0D8
`define RMCR_REG_LEAD_DLY 9'h0DB
`define RMCR_REG_PROTOCOL 9'h0DC
`define RMCR_REG_RETRY 9'h0DD
`define RMCR_REG_RX_ADDR 9'h0FC
`define RMCR_REG_TX_ADDR 9'h100
`define RMCR_REG_PIN 9'h0CD
`define RMCR_REG_PIN_EN 9'h0CF
`define RMCR_REG_LOW_PWR 9'h0E8
// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define RMCR_RST_RF_LEVEL 8'h03
`define RMCR_MAX_RF_LEVEL 8'h03
`define RMCR_RST_RATE 8'h04
`define RMCR_MIN_RATE 8'h01
`define RMCR_MAX_RATE 8'h07
`define RMCR_RST_DATA_LEN 8'h08
`define RMCR_DATA_LEN_7 8'h07
`define RMCR_RST_PARITY 8'h01
`define RMCR_MAX_PARITY 8'h03
`define RMCR_RST_STOP 8'h01
`define RMCR_MAX_STOP 8'h02
`define RMCR_RST_ESC_TMO 8'h08
`define RMCR_MAX_ESC_TMO 8'h64
`define RMCR_RST_IF_TYPE 8'h01
`define RMCR_FLOW_RTS 8'h00
`define RMCR_FLOW_NONE 8'h02
`define RMCR_RST_LEAD_DLY 8'h03
`define RMCR_MAX_LEAD_DLY 8'hA0
`define RMCR_RST_PROTOCOL 8'h02
`define RMCR_MAX_PROTOCOL 8'h04
`define RMCR_RST_RETRY 8'h00
`define RMCR_MAX_RETRY 8'h02
`define RMCR_RST_ADDR 16'h0000
`define RMCR_RST_PIN 16'h1111
`define RMCR_PIN_FORBIDDEN 16'h0000
// Escape floor: 4 chars of up to 12 bits, in 10 ms units
`define RMCR_ESC_FLOOR_1200 8'h04
`define RMCR_ESC_FLOOR_2400 8'h02
`define RMCR_ESC_FLOOR_FAST 8'h01
// ----------------------------------------
// Reply characters and timing
// ----------------------------------------
`define RMCR_CHR_OK 8'h4F
`define RMCR_CHR_ERR 8'h45
`define RMCR_CHR_CR 8'h0D
`define RMCR_CLK_NS 4
`define RMCR_ESC_UNIT_NS 10000000
`define RMCR_ESC_UNIT_CYC (`RMCR_ESC_UNIT_NS / `RMCR_CLK_NS)
`define RMCR_LEAD_UNIT_CYC 250
`endif

// ---- rmcr_pkg.sv ----
// Types shared by the radio modem configuration register bank
package rmcr_pkg;
  typedef enum logic [2:0] {
    RMCR_CMD_WRITE = 3'b000,
    RMCR_CMD_QUERY = 3'b001,
    RMCR_CMD_SAVE = 3'b010,
    RMCR_CMD_RESTORE = 3'b011,
    RMCR_CMD_PIN = 3'b100
  } rmcr_cmd_e;
  typedef enum logic [1:0] {
    RMCR_DE_IDLE = 2'b00,
    RMCR_DE_LEAD = 2'b01,
    RMCR_DE_SEND = 2'b10
  } rmcr_de_e;
  typedef struct packed {
    rmcr_cmd_e kind;
    logic [8:0] reg_num;
    logic [15:0] value;
  } rmcr_cmd_s;
  typedef struct packed {
    logic [7:0] rate;
    logic [7:0] data_len;
    logic [7:0] parity;
    logic [7:0] stop;
  } rmcr_fmt_s;
  typedef struct packed {
    logic [7:0] rf_level;
    rmcr_fmt_s fmt;
    logic [7:0] esc_tmo;
    logic [7:0] if_type;
    logic [7:0] flow;
    logic [7:0] lead_dly;
    logic [7:0] protocol;
    logic [7:0] retry;
    logic [15:0] rx_addr;
    logic [15:0] tx_addr;
    logic [15:0] pin;
    logic [7:0] pin_en;
    logic [7:0] low_pwr;
  } rmcr_cfg_s;
endpackage

// ---- rmcr_top.sv ----
// Radio modem configuration register bank with reply FIFO
`include "rmcr_defs.svh"

// ----------------------------------------
// Reply FIFO
// ----------------------------------------
module rmcr_fifo
  import rmcr_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Status
  output logic empty
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } rmcr_fptr_s;
  rmcr_fptr_s st_ff, nxt_st;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic do_push, do_pop;

  // Honest flags straight from the occupancy count
  assign in_ready = (st_ff.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_ff.cnt != '0);
  assign empty = ~out_valid;
  assign out_data = mem_ff[st_ff.rd];
  assign do_push = in_valid & in_ready;
  assign do_pop = out_valid & out_ready;

  // Pointer and count update
  always_comb begin
    nxt_st = st_ff;
    if (do_push) begin
      nxt_st.wr = st_ff.wr + 1'b1;
    end
    if (do_pop) begin
      nxt_st.rd = st_ff.rd + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Storage has no reset; out_valid guards its contents
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_ff[st_ff.wr] <= in_data;
    end
  end
endmodule // rmcr_fifo

// ----------------------------------------
// Register bank
// ----------------------------------------
module rmcr_top
  import rmcr_pkg::*;
#(
  parameter int ESC_UNIT_CYC = `RMCR_ESC_UNIT_CYC,
  parameter int LEAD_UNIT_CYC = `RMCR_LEAD_UNIT_CYC,
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Parsed command from the host link
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire rmcr_cmd_s cmd,
  output logic [15:0] query_value,
  // Reply characters toward the UART transmitter
  output logic reply_valid,
  input wire logic reply_ready,
  output logic [7:0] reply_char,
  input wire logic uart_tx_busy,
  // Nonvolatile storage
  input wire logic nv_load_valid,
  input wire rmcr_cfg_s nv_image,
  output logic nv_save,
  output rmcr_cfg_s cfg,
  // Serial format in force on the host link
  output rmcr_fmt_s link_fmt,
  output logic [16:0] link_bps,
  output logic hw_flow_en,
  // Escape silence
  input wire logic rx_char_seen,
  output logic silence_met,
  // RS485 line control
  input wire logic rs485_strap_n,
  input wire logic tx_req,
  output logic tx_go,
  output logic line_driver_enable,
  output logic line_receiver_enable_n,
  // Radio frame addressing
  input wire logic addressed_mode,
  input wire logic [15:0] rx_frame_addr,
  output logic rx_frame_keep,
  output logic [15:0] tx_frame_addr,
  // Power and protection
  input wire logic low_power_req,
  output logic low_power_grant,
  output logic cmd_locked
);
  typedef struct packed {
    rmcr_cfg_s cfg;
    rmcr_fmt_s fmt;
    logic fmt_pend;
    logic locked;
    logic cr_due;
    logic save;
    logic [15:0] qval;
    rmcr_de_e de;
    logic [7:0] lead_units;
    logic [15:0] lead_sub;
    logic [7:0] esc_units;
    logic [31:0] esc_sub;
  } rmcr_state_s;

  localparam rmcr_cfg_s CFG_RST = '{
    rf_level: `RMCR_RST_RF_LEVEL,
    fmt: '{rate: `RMCR_RST_RATE, data_len: `RMCR_RST_DATA_LEN,
           parity: `RMCR_RST_PARITY, stop: `RMCR_RST_STOP},
    esc_tmo: `RMCR_RST_ESC_TMO,
    if_type: `RMCR_RST_IF_TYPE,
    flow: `RMCR_FLOW_NONE,
    lead_dly: `RMCR_RST_LEAD_DLY,
    protocol: `RMCR_RST_PROTOCOL,
    retry: `RMCR_RST_RETRY,
    rx_addr: `RMCR_RST_ADDR,
    tx_addr: `RMCR_RST_ADDR,
    pin: `RMCR_RST_PIN,
    pin_en: 8'h00,
    low_pwr: 8'h00
  };

  rmcr_state_s st_ff, nxt_st;
  logic push_valid, push_ready, fifo_empty;
  logic [7:0] push_char;
  logic ok;
  logic [7:0] v8;
  logic hi_zero;
  logic rs485_on;

  // Fewest 10 ms units that hold four worst-case characters
  function automatic logic [7:0] esc_floor(input logic [7:0] rate);
    if (rate == `RMCR_MIN_RATE) begin
      esc_floor = `RMCR_ESC_FLOOR_1200;
    end else if (rate == 8'h02) begin
      esc_floor = `RMCR_ESC_FLOOR_2400;
    end else begin
      esc_floor = `RMCR_ESC_FLOOR_FAST;
    end
  endfunction

  // Rate code to bit rate, 1200 doubling up to 38400, then 57600
  function automatic logic [16:0] rate_bps(input logic [7:0] rate);
    unique case (rate)
      8'h01: rate_bps = 17'h004B0;
      8'h02: rate_bps = 17'h00960;
      8'h03: rate_bps = 17'h012C0;
      8'h04: rate_bps = 17'h02580;
      8'h05: rate_bps = 17'h04B00;
      8'h06: rate_bps = 17'h09600;
      default: rate_bps = 17'h0E100;
    endcase
  endfunction

  assign v8 = cmd.value[7:0];
  assign hi_zero = (cmd.value[15:8] == 8'h00);
  assign rs485_on = (st_ff.cfg.if_type == 8'h01) & ~rs485_strap_n;

  // Range check for a register write against the working copy
  always_comb begin
    ok = 1'b0;
    unique case (cmd.reg_num)
      `RMCR_REG_RF_LEVEL: ok = hi_zero & (v8 <= `RMCR_MAX_RF_LEVEL);
      `RMCR_REG_RATE: ok = hi_zero & (v8 >= `RMCR_MIN_RATE) & (v8 <= `RMCR_MAX_RATE);
      `RMCR_REG_DATA_LEN: ok = hi_zero & ((v8 == `RMCR_DATA_LEN_7) | (v8 == `RMCR_RST_DATA_LEN));
      `RMCR_REG_PARITY: ok = hi_zero & (v8 >= 8'h01) & (v8 <= `RMCR_MAX_PARITY);
      `RMCR_REG_STOP: ok = hi_zero & (v8 >= 8'h01) & (v8 <= `RMCR_MAX_STOP);
      `RMCR_REG_ESC_TMO: ok = hi_zero & (v8 >= 8'h01) & (v8 <= `RMCR_MAX_ESC_TMO);
      `RMCR_REG_IF_TYPE: ok = hi_zero & (v8 <= 8'h01);
      // Dropping RTS while retries are on would break the pairing
      `RMCR_REG_FLOW: ok = hi_zero & ((v8 == `RMCR_FLOW_RTS) |
                       ((v8 == `RMCR_FLOW_NONE) & (st_ff.cfg.retry == 8'h00)));
      `RMCR_REG_LEAD_DLY: ok = hi_zero & (v8 <= `RMCR_MAX_LEAD_DLY);
      `RMCR_REG_PROTOCOL: ok = hi_zero & (v8 >= 8'h02) & (v8 <= `RMCR_MAX_PROTOCOL);
      `RMCR_REG_RETRY: ok = hi_zero & (v8 <= `RMCR_MAX_RETRY) &
                       ((v8 == 8'h00) | (st_ff.cfg.flow == `RMCR_FLOW_RTS));
      `RMCR_REG_RX_ADDR: ok = 1'b1;
      `RMCR_REG_TX_ADDR: ok = 1'b1;
      `RMCR_REG_PIN: ok = (cmd.value != `RMCR_PIN_FORBIDDEN);
      `RMCR_REG_PIN_EN: ok = hi_zero & (v8 <= 8'h01);
      `RMCR_REG_LOW_PWR: ok = hi_zero & (v8 <= 8'h01);
      default: ok = 1'b0;
    endcase
  end

  // Command handling, format hand-over, line and silence timers
  always_comb begin
    nxt_st = st_ff;
    nxt_st.save = 1'b0;
    push_valid = 1'b0;
    push_char = `RMCR_CHR_CR;
    cmd_ready = 1'b0;
    if (st_ff.cr_due) begin
      push_valid = 1'b1;
      if (push_ready) begin
        nxt_st.cr_due = 1'b0;
      end
    end else if (nv_load_valid) begin
      nxt_st.cfg = nv_image;
      nxt_st.fmt = nv_image.fmt;
      nxt_st.fmt_pend = 1'b0;
      nxt_st.locked = nv_image.pin_en[0];
    end else if (cmd_valid & push_ready) begin
      cmd_ready = 1'b1;
      push_valid = 1'b1;
      push_char = `RMCR_CHR_OK;
      nxt_st.cr_due = 1'b1;
      if (st_ff.locked & (cmd.kind != RMCR_CMD_PIN)) begin
        push_char = `RMCR_CHR_ERR;
      end else begin
        unique case (cmd.kind)
          RMCR_CMD_WRITE: begin
            if (!ok) begin
              push_char = `RMCR_CHR_ERR;
            end else begin
              unique case (cmd.reg_num)
                `RMCR_REG_RF_LEVEL: nxt_st.cfg.rf_level = v8;
                `RMCR_REG_RATE: begin
                  nxt_st.cfg.fmt.rate = v8;
                  if (st_ff.cfg.esc_tmo < esc_floor(v8)) begin
                    nxt_st.cfg.esc_tmo = esc_floor(v8);
                  end
                end
                `RMCR_REG_DATA_LEN: nxt_st.cfg.fmt.data_len = v8;
                `RMCR_REG_PARITY: nxt_st.cfg.fmt.parity = v8;
                `RMCR_REG_STOP: nxt_st.cfg.fmt.stop = v8;
                `RMCR_REG_ESC_TMO: nxt_st.cfg.esc_tmo = v8;
                `RMCR_REG_IF_TYPE: nxt_st.cfg.if_type = v8;
                `RMCR_REG_FLOW: nxt_st.cfg.flow = v8;
                `RMCR_REG_LEAD_DLY: nxt_st.cfg.lead_dly = v8;
                `RMCR_REG_PROTOCOL: nxt_st.cfg.protocol = v8;
                `RMCR_REG_RETRY: nxt_st.cfg.retry = v8;
                `RMCR_REG_RX_ADDR: nxt_st.cfg.rx_addr = cmd.value;
                `RMCR_REG_TX_ADDR: nxt_st.cfg.tx_addr = cmd.value;
                `RMCR_REG_PIN: nxt_st.cfg.pin = cmd.value;
                `RMCR_REG_PIN_EN: nxt_st.cfg.pin_en = v8;
                default: nxt_st.cfg.low_pwr = v8;
              endcase
            end
          end
          RMCR_CMD_QUERY: begin
            // Value field is unused here, so only an unknown number is refused
            unique case (cmd.reg_num)
              `RMCR_REG_RF_LEVEL: nxt_st.qval = {8'h00, st_ff.cfg.rf_level};
              `RMCR_REG_RATE: nxt_st.qval = {8'h00, st_ff.cfg.fmt.rate};
              `RMCR_REG_DATA_LEN: nxt_st.qval = {8'h00, st_ff.cfg.fmt.data_len};
              `RMCR_REG_PARITY: nxt_st.qval = {8'h00, st_ff.cfg.fmt.parity};
              `RMCR_REG_STOP: nxt_st.qval = {8'h00, st_ff.cfg.fmt.stop};
              `RMCR_REG_ESC_TMO: nxt_st.qval = {8'h00, st_ff.cfg.esc_tmo};
              `RMCR_REG_IF_TYPE: nxt_st.qval = {8'h00, st_ff.cfg.if_type};
              `RMCR_REG_FLOW: nxt_st.qval = {8'h00, st_ff.cfg.flow};
              `RMCR_REG_LEAD_DLY: nxt_st.qval = {8'h00, st_ff.cfg.lead_dly};
              `RMCR_REG_PROTOCOL: nxt_st.qval = {8'h00, st_ff.cfg.protocol};
              `RMCR_REG_RETRY: nxt_st.qval = {8'h00, st_ff.cfg.retry};
              `RMCR_REG_RX_ADDR: nxt_st.qval = st_ff.cfg.rx_addr;
              `RMCR_REG_TX_ADDR: nxt_st.qval = st_ff.cfg.tx_addr;
              `RMCR_REG_PIN: nxt_st.qval = st_ff.cfg.pin;
              `RMCR_REG_PIN_EN: nxt_st.qval = {8'h00, st_ff.cfg.pin_en};
              `RMCR_REG_LOW_PWR: nxt_st.qval = {8'h00, st_ff.cfg.low_pwr};
              default: begin
                nxt_st.qval = 16'h0000;
                push_char = `RMCR_CHR_ERR;
              end
            endcase
          end
          RMCR_CMD_SAVE: nxt_st.save = 1'b1;
          RMCR_CMD_RESTORE: nxt_st.cfg = CFG_RST;
          default: begin
            // PIN entry: matching code unlocks, all-zero code restores defaults
            if (cmd.value == `RMCR_PIN_FORBIDDEN) begin
              nxt_st.cfg = CFG_RST;
              nxt_st.locked = 1'b0;
            end else if (cmd.value == st_ff.cfg.pin) begin
              nxt_st.locked = 1'b0;
            end else begin
              push_char = `RMCR_CHR_ERR;
            end
          end
        endcase
      end
    end
    // A command's change of the working format is held back until the reply has left; a stored image applies at once
    // except while a CR is due (ignored) or as a pending hand-over fires (link takes the pending format)
    if (nxt_st.cfg.fmt != st_ff.fmt) begin
      nxt_st.fmt_pend = 1'b1;
    end
    if (st_ff.fmt_pend & ~st_ff.cr_due & ~push_valid & fifo_empty & ~uart_tx_busy) begin
      nxt_st.fmt = st_ff.cfg.fmt;
      nxt_st.fmt_pend = 1'b0;
    end
    // Escape silence: count whole 10 ms units since the last character
    if (rx_char_seen) begin
      nxt_st.esc_sub = 32'h0;
      nxt_st.esc_units = 8'h00;
    end else if (st_ff.esc_units < st_ff.cfg.esc_tmo) begin
      if (st_ff.esc_sub == 32'(ESC_UNIT_CYC - 1)) begin
        nxt_st.esc_sub = 32'h0;
        nxt_st.esc_units = st_ff.esc_units + 8'h01;
      end else begin
        nxt_st.esc_sub = st_ff.esc_sub + 32'h1;
      end
    end
    // RS485 driver lead time before the first byte
    unique case (st_ff.de)
      RMCR_DE_IDLE: begin
        nxt_st.lead_units = 8'h00;
        nxt_st.lead_sub = 16'h0;
        if (tx_req & rs485_on) begin
          nxt_st.de = (st_ff.cfg.lead_dly == 8'h00) ? RMCR_DE_SEND : RMCR_DE_LEAD;
        end
      end
      RMCR_DE_LEAD: begin
        if (st_ff.lead_sub == 16'(LEAD_UNIT_CYC - 1)) begin
          nxt_st.lead_sub = 16'h0;
          nxt_st.lead_units = st_ff.lead_units + 8'h01;
          if (st_ff.lead_units + 8'h01 >= st_ff.cfg.lead_dly) begin
            nxt_st.de = RMCR_DE_SEND;
          end
        end else begin
          nxt_st.lead_sub = st_ff.lead_sub + 16'h1;
        end
      end
      RMCR_DE_SEND: begin
        if (!tx_req) begin
          nxt_st.de = RMCR_DE_IDLE;
        end
      end
      default: nxt_st.de = RMCR_DE_IDLE;
    endcase
    // Leaving RS485 mode drops the driver on the next clock edge, whatever the phase
    if (!rs485_on) begin
      nxt_st.de = RMCR_DE_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '{cfg: CFG_RST, fmt: CFG_RST.fmt, de: RMCR_DE_IDLE, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Reply path; a stalled UART backs up into cmd_ready
  rmcr_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_reply_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_char),
    .out_valid(reply_valid),
    .out_ready(reply_ready),
    .out_data(reply_char),
    .empty(fifo_empty)
  );

  // Outputs
  assign cfg = st_ff.cfg;
  assign query_value = st_ff.qval;
  assign nv_save = st_ff.save;
  assign link_fmt = st_ff.fmt;
  assign link_bps = rate_bps(st_ff.fmt.rate);
  // Overrun past 4800 baud without RTS is a host setup matter
  assign hw_flow_en = (st_ff.cfg.flow == `RMCR_FLOW_RTS);
  assign silence_met = (st_ff.esc_units >= st_ff.cfg.esc_tmo);
  assign line_driver_enable = (st_ff.de != RMCR_DE_IDLE);
  assign line_receiver_enable_n = (st_ff.de != RMCR_DE_IDLE);
  assign tx_go = rs485_on ? (st_ff.de == RMCR_DE_SEND) : tx_req;
  assign rx_frame_keep = ~addressed_mode | (rx_frame_addr == st_ff.cfg.rx_addr);
  assign tx_frame_addr = st_ff.cfg.tx_addr;
  assign low_power_grant = st_ff.cfg.low_pwr[0] & low_power_req;
  assign cmd_locked = st_ff.locked;
endmodule // rmcr_top

// ---- rmcr_asserts.sv ----
// Port checker for the radio modem configuration register bank
`include "rmcr_defs.svh"
module rmcr_asserts
  import rmcr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Command, reply and storage
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire rmcr_cmd_s cmd,
  input wire logic reply_valid,
  input wire logic [7:0] reply_char,
  input wire logic nv_save,
  input wire logic cmd_locked,
  input wire rmcr_cfg_s cfg,
  // Derived controls
  input wire logic hw_flow_en,
  input wire logic low_power_req,
  input wire logic low_power_grant,
  input wire logic addressed_mode,
  input wire logic [15:0] rx_frame_addr,
  input wire logic rx_frame_keep,
  input wire logic rs485_strap_n,
  input wire logic tx_req,
  input wire logic tx_go,
  input wire logic line_driver_enable,
  input wire logic line_receiver_enable_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic take;
  logic wr;
  logic rs485_on;
  // Command taken and line mode, shared by several properties
  assign take = cmd_valid && cmd_ready;
  assign wr = take && cmd.kind == RMCR_CMD_WRITE;
  assign rs485_on = cfg.if_type == 8'h01 && !rs485_strap_n;
  AST_REPLY: assert property (take |=> reply_valid) else $error("no reply after command");
  AST_FIRST_CHAR: assert property (take && !reply_valid |=> reply_char inside {8'h4F, 8'h45})
    else $error("reply head not O or E");
  AST_PAIR: assert property (take |=> !cmd_ready) else $error("command taken while CR due");
  AST_FLOW: assert property (hw_flow_en == (cfg.flow == `RMCR_FLOW_RTS)) else $error("flow mismatch");
  AST_RETRY: assert property (cfg.retry != 8'h00 |-> cfg.flow == `RMCR_FLOW_RTS) else $error("retry without RTS");
  AST_PIN: assert property (wr && cmd.reg_num == 9'h0CD && cmd.value == 16'h0000 |=> cfg.pin == $past(cfg.pin))
    else $error("zero pin accepted");
  AST_BAD_RF: assert property (wr && cmd.reg_num == 9'h0E7 && cmd.value > 16'h0003 |=> cfg == $past(cfg))
    else $error("bad level write changed registers");
  AST_SAVE: assert property (take && cmd.kind == RMCR_CMD_SAVE && !cmd_locked |=> nv_save)
    else $error("save gave no store pulse");
  AST_LOW_PWR: assert property (low_power_grant == (low_power_req && cfg.low_pwr[0])) else $error("grant wrong");
  AST_ADDR: assert property (addressed_mode && rx_frame_addr != cfg.rx_addr |-> !rx_frame_keep)
    else $error("foreign frame kept");
  AST_RS232: assert property (!rs485_on [*2] |-> tx_go == tx_req && !line_driver_enable)
    else $error("plain mode line control wrong");
  AST_LEAD: assert property ($rose(line_driver_enable) && cfg.lead_dly != 8'h00 |-> !tx_go)
    else $error("send without lead");
  AST_RX_OFF: assert property (line_receiver_enable_n == line_driver_enable) else $error("receiver on");
  // Main scenarios reached
  cover property (nv_save);
  cover property ($rose(line_driver_enable));
  cover property (take && cmd.kind == RMCR_CMD_PIN);
endmodule // rmcr_asserts
bind rmcr_top rmcr_asserts u_asserts (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd(cmd), .reply_valid(reply_valid), .reply_char(reply_char), .nv_save(nv_save), .cmd_locked(cmd_locked),
  .cfg(cfg), .hw_flow_en(hw_flow_en), .low_power_req(low_power_req), .low_power_grant(low_power_grant),
  .addressed_mode(addressed_mode), .rx_frame_addr(rx_frame_addr), .rx_frame_keep(rx_frame_keep),
  .rs485_strap_n(rs485_strap_n), .tx_req(tx_req), .tx_go(tx_go), .line_driver_enable(line_driver_enable),
  .line_receiver_enable_n(line_receiver_enable_n));

// ---- rmcr_host_model.sv ----
// Host link model that drains reply characters like a UART transmitter
module rmcr_host_model (
  // Clock and control
  input wire logic clk,
  input wire logic stall,
  // Reply stream
  input wire logic reply_valid,
  output logic reply_ready,
  input wire logic [7:0] reply_char,
  output logic uart_tx_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got_q [$];
  int busy_cnt = 0;
  initial begin
    reply_ready = 1'b0;
    uart_tx_busy = 1'b0;
  end
  // Each char keeps the shifter busy; a new one is only taken once it is out
  always @(posedge clk) begin
    if (reply_valid && reply_ready) begin
      got_q.push_back(reply_char);
      busy_cnt = 3;
    end else if (busy_cnt != 0) begin
      busy_cnt = busy_cnt - 1;
    end
    reply_ready <= !stall && busy_cnt == 0;
    uart_tx_busy <= busy_cnt != 0;
  end
endmodule // rmcr_host_model

// ---- tb_radio_modem_config_registers.sv ----
// Self-checking bench for the radio modem configuration register bank
`include "rmcr_defs.svh"
module tb_radio_modem_config_registers
  import rmcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [8:0] r; logic [15:0] v; logic ok; logic [15:0] rb;} rmcr_step_s;
  logic clk = 0, rstn = 0, cmd_valid = 0, stall = 0, nv_load_valid = 0, rs485_strap_n = 1, tx_req = 0;
  logic addressed_mode = 0, low_power_req = 0, rx_char_seen = 0;
  logic cmd_ready, reply_valid, reply_ready, uart_tx_busy, nv_save, hw_flow_en, silence_met, tx_go, de, re_n;
  logic rx_frame_keep, low_power_grant, cmd_locked;
  logic [15:0] rx_frame_addr = '0, query_value, tx_frame_addr;
  logic [7:0] reply_char;
  logic [16:0] link_bps;
  rmcr_cmd_s cmd = '0;
  rmcr_cfg_s nv_image = '0, cfg, dflt;
  rmcr_fmt_s link_fmt;
  int n_fail = 0, checks = 0, n;
  rmcr_step_s steps [24] = '{'{9'hE7,16'h4,1'b0,16'h3}, '{9'hD2,16'h8,1'b0,16'h4}, '{9'hD3,16'h6,1'b0,16'h8},
    '{9'hD3,16'h7,1'b1,16'h7}, '{9'hD4,16'h4,1'b0,16'h1}, '{9'hD4,16'h3,1'b1,16'h3}, '{9'hD5,16'h3,1'b0,16'h1},
    '{9'hD5,16'h2,1'b1,16'h2}, '{9'hD6,16'h65,1'b0,16'h8}, '{9'hD6,16'h1,1'b1,16'h1}, '{9'hD2,16'h1,1'b1,16'h1},
    '{9'hD6,16'h0,1'b0,16'h4}, '{9'hDB,16'hA1,1'b0,16'h3}, '{9'hDC,16'h1,1'b0,16'h2}, '{9'hDC,16'h4,1'b1,16'h4},
    '{9'hDD,16'h1,1'b0,16'h0}, '{9'hD8,16'h0,1'b1,16'h0}, '{9'hDD,16'h2,1'b1,16'h2}, '{9'hD8,16'h2,1'b0,16'h0},
    '{9'hCD,16'h0,1'b0,16'h1111}, '{9'hFC,16'hABCD,1'b1,16'hABCD}, '{9'h100,16'h5A5A,1'b1,16'h5A5A},
    '{9'hE8,16'h1,1'b1,16'h1}, '{9'hD7,16'h0,1'b1,16'h0}};
  always #2 clk = ~clk;
  rmcr_top #(.ESC_UNIT_CYC(10), .LEAD_UNIT_CYC(4)) uut (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .query_value(query_value), .reply_valid(reply_valid),
    .reply_ready(reply_ready), .reply_char(reply_char), .uart_tx_busy(uart_tx_busy), .nv_load_valid(nv_load_valid),
    .nv_image(nv_image), .nv_save(nv_save), .cfg(cfg), .link_fmt(link_fmt), .link_bps(link_bps),
    .hw_flow_en(hw_flow_en), .rx_char_seen(rx_char_seen), .silence_met(silence_met), .rs485_strap_n(rs485_strap_n),
    .tx_req(tx_req), .tx_go(tx_go), .line_driver_enable(de), .line_receiver_enable_n(re_n),
    .addressed_mode(addressed_mode), .rx_frame_addr(rx_frame_addr), .rx_frame_keep(rx_frame_keep),
    .tx_frame_addr(tx_frame_addr), .low_power_req(low_power_req), .low_power_grant(low_power_grant),
    .cmd_locked(cmd_locked));
  rmcr_host_model host (.clk(clk), .stall(stall), .reply_valid(reply_valid), .reply_ready(reply_ready),
    .reply_char(reply_char), .uart_tx_busy(uart_tx_busy));
  task automatic chk(input logic [151:0] got, input logic [151:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Present a command and hold it until the edge that takes it
  task automatic send(input rmcr_cmd_e k, input logic [8:0] r, input logic [15:0] v);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd = '{k, r, v};
    n = 0;
    #1;
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      #1;
      n++;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask
  // One command, then its two reply characters
  task automatic op(input rmcr_cmd_e k, input logic [8:0] r, input logic [15:0] v, input logic [7:0] exp);
    send(k, r, v);
    n = 0;
    while (host.got_q.size() < 2 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(host.got_q.pop_front(), exp);
    chk(host.got_q.pop_front(), `RMCR_CHR_CR);
  endtask
  task tally_and_finish;
    $display("mismatches %0d checks %0d", n_fail, checks);
    if (n_fail == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog: the sequence needs under a thousand cycles
  initial begin
    #100000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    dflt = '{8'h03, '{8'h04, 8'h08, 8'h01, 8'h01}, 8'h08, 8'h01, 8'h02, 8'h03, 8'h02, 8'h00, 16'h0, 16'h0, 16'h1111,
      8'h00, 8'h00};
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    low_power_req = 1'b1;
    @(negedge clk);
    chk(cfg, dflt);
    chk(low_power_grant, 1'b0);
    // Silence: eight units of ten cycles after the last char
    rx_char_seen = 1'b1;
    @(negedge clk);
    rx_char_seen = 1'b0;
    repeat (70) @(negedge clk);
    chk(silence_met, 1'b0);
    repeat (20) @(negedge clk);
    chk(silence_met, 1'b1);
    // Driver lead of three units of four cycles before sending
    rs485_strap_n = 1'b0;
    tx_req = 1'b1;
    n = 0;
    while (tx_go !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(n >= 12 && n <= 15, 1'b1);
    chk({de, re_n}, 2'b11);
    tx_req = 1'b0;
    repeat (2) @(negedge clk);
    chk(de, 1'b0);
    // Stalled host: sixteen chars fill the reply buffer
    stall = 1'b1;
    for (int i = 0; i < 8; i++) send(RMCR_CMD_QUERY, 9'h0E7, 16'h0);
    repeat (3) @(negedge clk);
    chk({cmd_ready, reply_valid}, 2'b01);
    stall = 1'b0;
    n = 0;
    while (host.got_q.size() < 16 && n < 200) begin
      @(negedge clk);
      n++;
    end
    for (int i = 0; i < 16; i++) chk(host.got_q.pop_front(), i[0] ? `RMCR_CHR_CR : `RMCR_CHR_OK);
    // Every write is read back, good and bad values alike
    foreach (steps[i]) begin
      op(RMCR_CMD_WRITE, steps[i].r, steps[i].v, steps[i].ok ? `RMCR_CHR_OK : `RMCR_CHR_ERR);
      op(RMCR_CMD_QUERY, steps[i].r, 16'h0, `RMCR_CHR_OK);
      chk(query_value, steps[i].rb);
    end
    repeat (10) @(negedge clk);
    chk(link_fmt, {8'h01, 8'h07, 8'h03, 8'h02});
    chk(link_bps, 17'h004B0);
    chk(hw_flow_en, 1'b1);
    chk({low_power_grant, tx_frame_addr}, 17'h15A5A);
    tx_req = 1'b1;
    addressed_mode = 1'b1;
    rx_frame_addr = 16'hABCD;
    @(negedge clk);
    chk({tx_go, de, rx_frame_keep}, 3'b101);
    rx_frame_addr = 16'h1234;
    @(negedge clk);
    chk(rx_frame_keep, 1'b0);
    // Stored image with protection on locks the command set
    nv_image = dflt;
    nv_image.pin = 16'h1234;
    nv_image.pin_en = 8'h01;
    nv_load_valid = 1'b1;
    @(negedge clk);
    nv_load_valid = 1'b0;
    @(negedge clk);
    chk({cmd_locked, cfg}, {1'b1, nv_image});
    op(RMCR_CMD_QUERY, 9'h0E7, 16'h0, `RMCR_CHR_ERR);
    op(RMCR_CMD_PIN, 9'h0, 16'h4321, `RMCR_CHR_ERR);
    op(RMCR_CMD_PIN, 9'h0, 16'h1234, `RMCR_CHR_OK);
    chk(cmd_locked, 1'b0);
    op(RMCR_CMD_SAVE, 9'h0, 16'h0, `RMCR_CHR_OK);
    op(RMCR_CMD_RESTORE, 9'h0, 16'h0, `RMCR_CHR_OK);
    chk(cfg, dflt);
    tally_and_finish();
  end
endmodule // tb_radio_modem_config_registers
